// *** sim/ferx_mac_model.sv ***
// Purpose: MAC side model that collects the received MII words.
// Assumes: rx_stb marks each receive word time.
// Notes:   A word with dv and er low is kept only where it ends a frame.

`timescale 1ns/1ps
`default_nettype none

module ferx_mac_model
   import ferx_pkg::*;
(
   // Clock
   input wire logic clk,
   // MII receive
   input wire logic rx_stb,
   input wire logic [3:0] rxd,
   input wire logic rx_dv,
   input wire logic rx_er
);
   ferx_mii_type got[$];
   logic prev_dv;

   initial prev_dv = 1'b0;

   // Old values are read at the edge, so this sees the word of the strobe cycle
   always @(posedge clk) begin
      if (rx_stb === 1'b1) begin
         if (rx_dv || rx_er || prev_dv) begin
            got.push_back({rxd, rx_dv, rx_er});
         end
         prev_dv <= rx_dv;
      end
   end
endmodule

`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the receive coding path.
// Assumes: The line is fed as scrambled NRZI groups, first bit in bit 4.
// Notes:   Expected words are queued as the groups are sent, compared at the end.

`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import ferx_pkg::*;

   logic clk, rst_n, lrx_clk, speed_10, full_duplex, tx_en;
   logic rx_dv, rx_er, rx_stb, crs, col, tx_take, tx_manch, rx_lock;
   logic line_rx = 1'b0;
   logic line_lvl = 1'b0;
   logic man_lvl = 1'b0;
   logic [4:0] sh, cg_next;
   int nb = 0;
   int n_req = 0;
   int n_sent = 0;
   logic [3:0] rxd, txd, last_nib, nib;
   logic [15:0] rnd;
   logic [10:0] scr = 11'h5a5;
   int n_mismatch, checked, cyc;
   ferx_mii_type exp_q[$];
   logic [4:0] tbl [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                            5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
   logic [4:0] bad [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19};

   ferx_rx_pcs u_dut (.clk(clk), .rst_n(rst_n), .lrx_clk(lrx_clk), .line_rx(line_rx), .speed_10(speed_10),
      .full_duplex(full_duplex), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .rx_stb(rx_stb), .crs(crs),
      .col(col), .tx_en(tx_en), .txd(txd), .tx_take(tx_take), .tx_manch(tx_manch), .rx_lock(rx_lock));
   ferx_mac_model u_mac (.clk(clk), .rx_stb(rx_stb), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er));

   always #5 clk = ~clk;
   initial begin
      lrx_clk = 1'b0;
      #1.3;
      forever #3 lrx_clk = ~lrx_clk;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [3:0] draw();
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      return rnd[3:0];
   endfunction

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (n_mismatch == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Hands one group to the line driver and returns once its last bit is on the line
   task automatic send_cg(input logic [4:0] cg);
      cg_next = cg;
      n_req++;
      wait (n_sent == n_req);
   endtask

   // One Manchester bit cell as two samples; a one is low then high
   task automatic send_man(input logic b);
      @(negedge lrx_clk) man_lvl = ~b;
      @(negedge lrx_clk) man_lvl = b;
   endtask

   // At 100M the line never rests: idle bits fill every gap, or the far descrambler falls out of step
   always @(posedge lrx_clk) begin : line_drv
      logic key;
      if (speed_10) begin
         line_rx <= man_lvl;
      end else begin
         if (nb == 0 && n_sent != n_req) begin
            sh = cg_next;
            nb = 5;
         end
         key = scr[10] ^ scr[8];
         scr = {scr[9:0], key};
         if ((nb == 0 || sh[4]) ^ key) line_lvl = ~line_lvl;
         if (nb != 0) begin
            sh = {sh[3:0], 1'b0};
            nb--;
            if (nb == 0) n_sent++;
         end
         line_rx <= line_lvl;
      end
   end

   // Sends a group inside a frame and queues the word it should give
   task automatic grp(input logic [4:0] cg);
      int n;
      n = -1;
      for (int i = 0; i < 16; i++) if (tbl[i] == cg) n = i;
      if (n >= 0) begin
         last_nib = 4'(n);
         exp_q.push_back({4'(n), 2'b10});
      end else if (cg == 5'h18 || cg == 5'h11) begin
         last_nib = 4'h5;
         exp_q.push_back({4'h5, 2'b10});
      end else if (cg == 5'h0d || cg == 5'h1f) begin
         exp_q.push_back({4'h0, 2'b00});
      end else begin
         exp_q.push_back({last_nib, 2'b11});
      end
      send_cg(cg);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      ferx_mii_type g;
      clk = 1'b0;
      rst_n = 1'b0;
      speed_10 = 1'b0;
      full_duplex = 1'b0;
      tx_en = 1'b0;
      txd = 4'h0;
      rnd = 16'h9a5a;
      last_nib = 4'h0;
      n_mismatch = 0;
      checked = 0;
      cyc = 0;
      repeat (4) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      repeat (12) send_cg(5'h1f);
      repeat (6) @(negedge clk);
      check("rx_lock", 8'(rx_lock), 8'h01);
      fork
         begin
            grp(5'h18);
            grp(5'h11);
            for (int i = 0; i < 16; i++) grp(tbl[i]);
            grp(5'h04);
            for (int i = 0; i < 10; i++) begin
               grp(tbl[draw()]);
               grp(bad[i]);
            end
            grp(5'h0d);
            send_cg(5'h07);
            repeat (4) send_cg(5'h1f);
         end
         begin
            @(posedge rx_dv);
            @(negedge clk) tx_en = 1'b1;
            repeat (4) @(negedge clk);
            check("col half", 8'(col), 8'h01);
            check("crs half", 8'(crs), 8'h01);
            full_duplex = 1'b1;
            repeat (6) @(negedge clk);
            check("col full", 8'(col), 8'h00);
            check("crs full rx", 8'(crs), 8'h01);
         end
      join
      repeat (4) @(negedge clk);
      check("crs full tx", 8'(crs), 8'h00);
      full_duplex = 1'b0;
      repeat (6) @(negedge clk);
      check("crs half tx", 8'(crs), 8'h01);
      check("col tx only", 8'(col), 8'h00);
      tx_en = 1'b0;
      // J without K, then a frame cut by idle, then one right behind it
      grp(5'h18);
      exp_q.push_back({4'he, 2'b01});
      send_cg(tbl[draw()]);
      repeat (3) send_cg(5'h1f);
      grp(5'h18);
      grp(5'h11);
      repeat (3) grp(tbl[draw()]);
      grp(5'h1f);
      grp(5'h18);
      grp(5'h11);
      grp(tbl[draw()]);
      grp(5'h0d);
      send_cg(5'h07);
      repeat (6) send_cg(5'h1f);
      // 10M receive: preamble, SFD, two nibbles, two stray bits, then a cell with no mid edge.
      // The stray bits keep the closing word clear of the last nibble at this fast line clock.
      @(negedge clk) speed_10 = 1'b1;
      for (int i = 0; i < 10; i++) send_man(i[0] == 1'b0 || i == 9);
      exp_q.push_back({4'hd, 2'b10});
      repeat (2) begin
         nib = draw();
         exp_q.push_back({nib, 2'b10});
         for (int b = 0; b < 4; b++) send_man(nib[b]);
      end
      send_man(1'b1);
      send_man(1'b0);
      exp_q.push_back({4'h0, 2'b00});
      repeat (10) @(negedge clk);
      check("rx word count", 8'(u_mac.got.size()), 8'(exp_q.size()));
      foreach (exp_q[i]) begin
         if (i < u_mac.got.size()) begin
            g = u_mac.got[i];
            if (!exp_q[i].dv && !exp_q[i].er) g.rxd = 4'h0;
            check("rx word", 8'(g), 8'(exp_q[i]));
         end
      end
      // 10M transmit: one Manchester nibble, then the line rests low
      speed_10 = 1'b1;
      nib = draw();
      repeat (6) @(negedge clk);
      txd = nib;
      tx_en = 1'b1;
      for (int k = 0; k < 10 && tx_take !== 1'b1; k++) @(negedge clk);
      check("tx_take", 8'(tx_take), 8'h01);
      tx_en = 1'b0;
      for (int b = 0; b < 4; b++) begin
         repeat (2) @(negedge clk);
         check("manch first half", 8'(tx_manch), {7'h0, ~nib[b]});
         repeat (5) @(negedge clk);
         check("manch second half", 8'(tx_manch), 8'(nib[b]));
         repeat (3) @(negedge clk);
      end
      repeat (3) @(negedge clk);
      check("manch idle", 8'(tx_manch), 8'h00);
      end_of_test();
   end
endmodule

`default_nettype wire

// *** verilog/ferx_pkg.sv ***
// Purpose: Shared constants, code tables and state types for the receive coding path.
// Assumes: Code groups are held with the first line bit in bit 4.
// Notes:   Every number used by the logic is named here.

package ferx_pkg;

   // ----------------------------------------------------------------
   // Code groups
   // ----------------------------------------------------------------
   localparam int CG_W = 5;
   localparam logic [CG_W-1:0] CG_DATA [16] = '{
      5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
   localparam logic [CG_W-1:0] CG_I = 5'h1f;
   localparam logic [CG_W-1:0] CG_J = 5'h18;
   localparam logic [CG_W-1:0] CG_K = 5'h11;
   localparam logic [CG_W-1:0] CG_T = 5'h0d;
   localparam logic [CG_W-1:0] CG_R = 5'h07;
   localparam logic [CG_W-1:0] CG_H = 5'h04;
   localparam logic [2*CG_W-1:0] CG_IJ = {CG_I, CG_J};
   localparam logic [2:0] CG_LAST = 3'h4;

   // ----------------------------------------------------------------
   // Nibbles, descrambler and timing
   // ----------------------------------------------------------------
   localparam logic [3:0] NIB_PRE = 4'h5;
   localparam logic [3:0] NIB_SFD = 4'hd;
   localparam logic [3:0] NIB_FALSE = 4'he;
   localparam logic [1:0] NIB_LAST = 2'h3;
   localparam int LFSR_W = 11;
   localparam int LFSR_TAP_A = 10;
   localparam int LFSR_TAP_B = 8;
   localparam logic [4:0] LOCK_LAST = 5'h1d;
   localparam int CLK_MHZ = 100;
   localparam int MAN_HALF_NS = 50;
   localparam int MAN_HALF_CYC = (MAN_HALF_NS * CLK_MHZ) / 1000;
   localparam logic [2:0] MAN_HALF_LAST = 3'(MAN_HALF_CYC - 1);

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CK_DATA = 3'b000, CK_IDLE = 3'b001, CK_J = 3'b010, CK_K = 3'b011,
      CK_T = 3'b100, CK_R = 3'b101, CK_H = 3'b110, CK_INV = 3'b111
   } ferx_kind_type;
   typedef enum logic [1:0] {RS_IDLE = 2'b00, RS_JK = 2'b01, RS_FRAME = 2'b10} ferx_rxst_type;
   typedef enum logic {TS_IDLE = 1'b0, TS_RUN = 1'b1} ferx_txst_type;
   typedef struct packed {ferx_kind_type kind; logic [3:0] nib;} ferx_dec_type;
   typedef struct packed {logic raw; logic [CG_W-1:0] code;} ferx_lword_type;
   typedef struct packed {logic [3:0] rxd; logic dv; logic er;} ferx_mii_type;

   typedef struct packed {
      logic rs1; logic rs2; logic md1; logic md2; logic ln1; logic ln2; logic ln_prev;
      logic [LFSR_W-1:0] lfsr; logic lock; logic [4:0] lk_cnt;
      logic [2*CG_W-1:0] sr; logic aligned; logic [2:0] gcnt;
      logic tog; ferx_lword_type buf0; ferx_lword_type buf1;
      logic m_ph; logic m_prev; logic m_on; logic m_one; logic [3:0] m_nb; logic [1:0] m_cnt;
   } ferx_lnk_type;

   typedef struct packed {
      logic t1; logic t2; logic t3; logic lk1; logic lk2; logic fd1; logic fd2; logic sp1; logic sp2;
      ferx_rxst_type rxs; ferx_mii_type mii; logic stb; logic crs; logic col;
      ferx_txst_type tst; logic [3:0] tsh; logic [1:0] tbit; logic thalf; logic [2:0] tcnt;
      logic txo; logic take;
   } ferx_sys_type;

   // Table lookup; anything not listed falls out as invalid
   function automatic ferx_dec_type ferx_decode(input logic [CG_W-1:0] cg);
      ferx_dec_type r;
      r.kind = CK_INV;
      r.nib = '0;
      for (int i = 0; i < 16; i++) begin
         if (cg == CG_DATA[i]) begin
            r.kind = CK_DATA;
            r.nib = 4'(i);
         end
      end
      case (cg)
         CG_I: r.kind = CK_IDLE;
         CG_J: r.kind = CK_J;
         CG_K: r.kind = CK_K;
         CG_T: r.kind = CK_T;
         CG_R: r.kind = CK_R;
         CG_H: r.kind = CK_H;
         default: begin
         end
      endcase
      return r;
   endfunction

endpackage

// *** verilog/ferx_rx_pcs.sv ***
// Purpose: Receive coding path: line bits to MII nibbles, plus carrier, collision and 10M coding.
// Assumes: lrx_clk is the recovered bit clock (125 MHz, or twice the bit rate at 10M);
//          tx_en and txd are synchronous to clk.
// Notes:   Words cross from the line domain through a ping-pong pair and a toggle.
//
// Functional notes
// - Data codes map to nibbles 0 to 7.
// - Data codes map to nibbles 8 to F.
// - 11111 is idle, no frame in progress.
// - 11000 is J, stands for preamble 0101.
// - 10001 is K, stands for preamble 0101.
// - 01101 is T, no nibble value.
// - 00111 is R, no nibble value.
// - 00100 is H, error symbol.
// - Remaining ten codes are invalid symbols.
// - Serial line stream becomes synchronous 4-bit nibbles.
// - Run line logic on recovered 125 MHz clock.
// - Undo NRZI before deserialising.
// - Deserialise, descramble, hand to alignment.
// - Find J/K, then cut fixed 5-bit groups.
// - First two groups of frame are J/K.
// - Replace J/K with two preamble nibbles.
// - Strip T/R, never shown as nibbles.
// - 10M mode uses Manchester decode and encode.
// - Half duplex: collision when transmitting while receiving.
// - Full duplex: collision never asserted.
// - Carrier sense from transmit or receive per duplex.
// - Data valid covers frame, excludes end delimiter.
// - Receive error flags a detected frame error.

`timescale 1ns/1ps
`default_nettype none

module ferx_rx_pcs
   import ferx_pkg::*;
(
   // System clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Line side
   input wire logic lrx_clk,
   input wire logic line_rx,
   // Mode pins
   input wire logic speed_10,
   input wire logic full_duplex,
   // MII receive
   output logic [3:0] rxd,
   output logic rx_dv,
   output logic rx_er,
   output logic rx_stb,
   output logic crs,
   output logic col,
   // MII transmit and 10M line out
   input wire logic tx_en,
   input wire logic [3:0] txd,
   output logic tx_take,
   output logic tx_manch,
   // Status
   output logic rx_lock
);

   ferx_lnk_type l;
   ferx_lnk_type ln;
   ferx_sys_type s;
   ferx_sys_type sn;
   logic l_send;
   ferx_lword_type l_w;
   logic nrz;
   logic key;
   logic plain;
   ferx_lword_type s_w;
   logic s_got;
   ferx_dec_type s_d;

   // ----------------------------------------------------------------
   // Line domain
   // ----------------------------------------------------------------
   assign nrz = l.ln2 ^ l.ln_prev;
   assign key = l.lfsr[LFSR_TAP_A] ^ l.lfsr[LFSR_TAP_B];
   assign plain = nrz ^ key;

   always_comb begin
      ferx_lnk_type z;
      z = '0;
      ln = l;
      l_send = 1'b0;
      l_w = '0;
      ln.rs1 = rst_n;
      ln.rs2 = l.rs1;
      ln.md1 = speed_10;
      ln.md2 = l.md1;
      ln.ln1 = line_rx;
      ln.ln2 = l.ln1;
      ln.ln_prev = l.ln2;

      // Idle plaintext is all ones, so while unlocked the key is the inverted line bit
      if (!l.lock) begin
         ln.lfsr = {l.lfsr[LFSR_W-2:0], ~nrz};
         if (plain) begin
            ln.lk_cnt = l.lk_cnt + 5'h1;
            if (l.lk_cnt == LOCK_LAST) begin
               ln.lock = 1'b1;
            end
         end else begin
            ln.lk_cnt = '0;
         end
      end else begin
         ln.lfsr = {l.lfsr[LFSR_W-2:0], key};
      end
      ln.sr = {l.sr[2*CG_W-2:0], plain};

      if (l.md2 || !l.lock) begin
         ln.aligned = 1'b0;
      end else if (!l.aligned) begin
         // Idle then J marks the start delimiter; K is checked on the next group
         if (ln.sr == CG_IJ) begin
            ln.aligned = 1'b1;
            ln.gcnt = '0;
            l_send = 1'b1;
            l_w = '{raw: 1'b0, code: CG_J};
         end
      end else if (l.gcnt == CG_LAST) begin
         ln.gcnt = '0;
         l_send = 1'b1;
         l_w = '{raw: 1'b0, code: ln.sr[CG_W-1:0]};
         if (ln.sr[CG_W-1:0] == CG_I || ln.sr[CG_W-1:0] == CG_R) begin
            ln.aligned = 1'b0;
         end
      end else begin
         ln.gcnt = l.gcnt + 3'h1;
      end

      // 10M: the clock runs at two samples per bit cell
      if (l.md2) begin
         ln.m_ph = ~l.m_ph;
         ln.m_prev = l.ln2;
         if (l.m_ph) begin
            if (l.m_prev == l.ln2) begin
               ln.m_one = 1'b0;
               if (l.m_on) begin
                  ln.m_on = 1'b0;
                  l_send = 1'b1;
                  l_w = '{raw: 1'b0, code: CG_T};
               end else begin
                  // No mid-cell edge: slip half a cell to find the boundary
                  ln.m_ph = l.m_ph;
               end
            end else if (!l.m_on) begin
               ln.m_one = l.ln2;
               if (l.ln2 && l.m_one) begin
                  ln.m_on = 1'b1;
                  ln.m_cnt = '0;
                  l_send = 1'b1;
                  l_w = '{raw: 1'b1, code: {1'b0, NIB_SFD}};
               end
            end else begin
               ln.m_nb = {l.ln2, l.m_nb[3:1]};
               ln.m_cnt = l.m_cnt + 2'h1;
               if (l.m_cnt == NIB_LAST) begin
                  l_send = 1'b1;
                  l_w = '{raw: 1'b1, code: {1'b0, ln.m_nb}};
               end
            end
         end
      end else begin
         ln.m_on = 1'b0;
         ln.m_one = 1'b0;
      end

      // Each buffer stays still for two word times, which covers the toggle's crossing
      if (l_send) begin
         ln.tog = ~l.tog;
         if (l.tog) begin
            ln.buf0 = l_w;
         end else begin
            ln.buf1 = l_w;
         end
      end

      if (!l.rs2) begin
         z.rs1 = ln.rs1;
         z.rs2 = ln.rs2;
         z.md1 = ln.md1;
         z.md2 = ln.md2;
         z.ln1 = ln.ln1;
         z.ln2 = ln.ln2;
         ln = z;
      end
   end

   always_ff @(posedge lrx_clk) begin
      l <= ln;
   end

   // ----------------------------------------------------------------
   // System domain: delimiter handling and MII
   // ----------------------------------------------------------------
   assign s_got = s.t2 ^ s.t3;
   assign s_w = s.t2 ? l.buf1 : l.buf0;
   assign s_d = ferx_decode(s_w.code);

   always_comb begin
      sn = s;
      sn.t1 = l.tog;
      sn.t2 = s.t1;
      sn.t3 = s.t2;
      sn.lk1 = l.lock;
      sn.lk2 = s.lk1;
      sn.fd1 = full_duplex;
      sn.fd2 = s.fd1;
      sn.sp1 = speed_10;
      sn.sp2 = s.sp1;
      sn.stb = 1'b0;
      sn.take = 1'b0;

      if (s_got) begin
         sn.stb = 1'b1;
         sn.mii.er = 1'b0;
         if (s_w.raw) begin
            sn.mii.dv = 1'b1;
            sn.mii.rxd = s_w.code[3:0];
            sn.rxs = RS_FRAME;
         end else begin
            case (s.rxs)
               RS_IDLE: begin
                  sn.mii.dv = 1'b0;
                  if (s_d.kind == CK_J) begin
                     sn.mii.dv = 1'b1;
                     sn.mii.rxd = NIB_PRE;
                     sn.rxs = RS_JK;
                  end
               end
               RS_JK: begin
                  if (s_d.kind == CK_K) begin
                     sn.mii.rxd = NIB_PRE;
                     sn.rxs = RS_FRAME;
                  end else begin
                     // J without K: report a false carrier, outside any frame
                     sn.mii.dv = 1'b0;
                     sn.mii.er = 1'b1;
                     sn.mii.rxd = NIB_FALSE;
                     sn.rxs = RS_IDLE;
                  end
               end
               RS_FRAME: begin
                  case (s_d.kind)
                     CK_DATA: sn.mii.rxd = s_d.nib;
                     CK_T, CK_R, CK_IDLE: begin
                        sn.mii.dv = 1'b0;
                        sn.rxs = RS_IDLE;
                     end
                     default: sn.mii.er = 1'b1;
                  endcase
               end
               default: sn.rxs = RS_IDLE;
            endcase
         end
      end else if (!s.sp2 && !s.lk2 && s.rxs != RS_IDLE) begin
         // Descrambler lost: close the frame rather than hang in it
         sn.mii.dv = 1'b0;
         sn.mii.er = 1'b0;
         sn.rxs = RS_IDLE;
      end

      sn.crs = (s.rxs != RS_IDLE) | (!s.fd2 & tx_en);
      sn.col = !s.fd2 & tx_en & (s.rxs != RS_IDLE);

      // 10M transmit: a one is low then high within the cell
      case (s.tst)
         TS_IDLE: begin
            sn.txo = 1'b0;
            if (s.sp2 && tx_en) begin
               sn.tst = TS_RUN;
               sn.tsh = txd;
               sn.take = 1'b1;
               sn.tbit = '0;
               sn.thalf = 1'b0;
               sn.tcnt = '0;
               sn.txo = ~txd[0];
            end
         end
         TS_RUN: begin
            if (s.tcnt != MAN_HALF_LAST) begin
               sn.tcnt = s.tcnt + 3'h1;
            end else begin
               sn.tcnt = '0;
               if (!s.thalf) begin
                  sn.thalf = 1'b1;
                  sn.txo = s.tsh[0];
               end else begin
                  sn.thalf = 1'b0;
                  if (s.tbit != NIB_LAST) begin
                     sn.tbit = s.tbit + 2'h1;
                     sn.tsh = {1'b0, s.tsh[3:1]};
                     sn.txo = ~s.tsh[1];
                  end else if (tx_en && s.sp2) begin
                     sn.tsh = txd;
                     sn.take = 1'b1;
                     sn.tbit = '0;
                     sn.txo = ~txd[0];
                  end else begin
                     sn.tst = TS_IDLE;
                     sn.txo = 1'b0;
                  end
               end
            end
         end
         default: sn.tst = TS_IDLE;
      endcase

      if (!rst_n) begin
         sn = '0;
      end
   end

   always_ff @(posedge clk) begin
      s <= sn;
   end

   assign rxd = s.mii.rxd;
   assign rx_dv = s.mii.dv;
   assign rx_er = s.mii.er;
   assign rx_stb = s.stb;
   assign crs = s.crs;
   assign col = s.col;
   assign tx_take = s.take;
   assign tx_manch = s.txo;
   assign rx_lock = s.lk2;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_col_fdx_off: assert property (@(posedge clk) disable iff (!rst_n) s.fd2 |=> !col)
      else $error("collision raised in full duplex");
   a_col_half_dup: assert property (@(posedge clk) disable iff (!rst_n)
      (!s.fd2 && tx_en && s.rxs != RS_IDLE) |=> col)
      else $error("collision missed in half duplex");
   a_crs_fdx_tx: assert property (@(posedge clk) disable iff (!rst_n)
      (s.fd2 && s.rxs == RS_IDLE) |=> !crs)
      else $error("carrier sense from transmit in full duplex");
   a_crs_hdx_tx: assert property (@(posedge clk) disable iff (!rst_n) (!s.fd2 && tx_en) |=> crs)
      else $error("carrier sense missing while transmitting");
   a_jk_preamble: assert property (@(posedge clk) disable iff (!rst_n)
      (s_got && !s_w.raw && ((s.rxs == RS_IDLE && s_d.kind == CK_J) || (s.rxs == RS_JK && s_d.kind == CK_K)))
      |=> (rx_dv && rxd == NIB_PRE))
      else $error("J or K not replaced by preamble");
   a_tr_strip: assert property (@(posedge clk) disable iff (!rst_n)
      (s_got && !s_w.raw && s.rxs == RS_FRAME && s_d.kind == CK_T) |=> !rx_dv ##1 !rx_dv)
      else $error("end delimiter reached the MAC");
   a_bad_keep_dv: assert property (@(posedge clk) disable iff (!rst_n)
      (s_got && !s_w.raw && s.rxs == RS_FRAME && (s_d.kind == CK_H || s_d.kind == CK_INV))
      |=> (rx_er && rx_dv && rxd == $past(rxd)))
      else $error("bad group did not flag error in frame");
   a_data_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (s_got && !s_w.raw && s.rxs == RS_FRAME && s_w.code == CG_DATA[0]) |=> (rxd == 4'h0 && !rx_er))
      else $error("data 0 decoded wrongly");
   a_data_fifteen: assert property (@(posedge clk) disable iff (!rst_n)
      (s_got && !s_w.raw && s.rxs == RS_FRAME && s_w.code == CG_DATA[15]) |=> (rxd == 4'hf))
      else $error("data F decoded wrongly");
   a_stb_pulse: assert property (@(posedge clk) disable iff (!rst_n) rx_stb |=> !rx_stb)
      else $error("nibble strobe longer than one cycle");
   a_tx_mid_edge: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(s.thalf) |-> tx_manch != $past(tx_manch))
      else $error("no mid-cell transition on 10M transmit");
   a_lock_count: assert property (@(posedge lrx_clk) disable iff (!l.rs2)
      $rose(l.lock) |-> $past(l.lk_cnt) == LOCK_LAST)
      else $error("descrambler locked early");
   a_idle_unalign: assert property (@(posedge lrx_clk) disable iff (!l.rs2)
      (l.aligned && l_send && l_w.code == CG_I) |=> !l.aligned)
      else $error("alignment kept after idle");

endmodule

`default_nettype wire
